// File: pin_sync.sv
// two-flop synchroniser for a vector of pin inputs
// assumes pins are asynchronous to clk_i
`timescale 1ns/100ps
module pin_sync #(
   parameter int WIDTH = 8
) (
   input  wire logic             clk_i,
   input  wire logic             rst_i,
   input  wire logic [WIDTH-1:0] async_i,
   output logic      [WIDTH-1:0] sync_o
);
   logic [WIDTH-1:0] meta;
   genvar g;
   generate
      for (g = 0; g < WIDTH; g++) begin : g_bit
         always_ff @(posedge clk_i) begin
            if (rst_i) begin
               meta[g]   <= 1'b0;
               sync_o[g] <= 1'b0;
            end else begin
               meta[g]   <= async_i[g];
               sync_o[g] <= meta[g];
            end
         end
      end
   endgenerate
endmodule // pin_sync

// File: quint_latch_cfg.svh
// constants for the five-bit latch bank
// assumes inclusion by the package and the design files
`ifndef QUINT_LATCH_CFG_SVH
`define QUINT_LATCH_CFG_SVH
`define LATCH_COUNT      5
`define LATCH_RESET_VAL  5'h00
`define PIN_SYNC_STAGES  2
`endif

// File: quint_latch_far_side.sv
// far-side logic model: drives the latch clocks, reset and data pins
// assumes the bench hands it one request word per step
`timescale 1ns/100ps
module quint_latch_far_side
   import quint_latch_pkg::*;
(
   input  wire logic           clk_i,
   input  wire logic [7:0]     req_i,
   output latch_ctrl_type      ctrl_o,
   output latch_word_type      data_o
);
   // pins move on the falling edge, away from the design's sampling edge
   always @(negedge clk_i) begin
      ctrl_o <= req_i[7:5];
      data_o <= req_i[4:0];
   end
endmodule // quint_latch_far_side

// File: quint_latch_pkg.sv
// types shared by the latch bank
// assumes quint_latch_cfg.svh is on the include path
`include "quint_latch_cfg.svh"
package quint_latch_pkg;
   typedef logic [`LATCH_COUNT-1:0] latch_word_type;
   typedef struct packed {
      logic clock_in_a;
      logic clock_in_b;
      logic reset;
   } latch_ctrl_type;
   typedef enum logic [0:0] {
      st_pass = 1'b0,
      st_hold = 1'b1
   } latch_state_type;
endpackage

// File: quint_transparent_latch.sv
// five-bit level-sensitive latch bank modelled on the system clock
// assumes all pins are asynchronous; each passes two flops first, so
// outputs lag the pins by three clk_i cycles
`timescale 1ns/100ps
`include "quint_latch_cfg.svh"

// Overview of operation
// - five latches share one reset and clock
// - combined clock is OR of both
// - clock low: outputs follow data
// - rising clock captures data and holds it
// - clock high: data changes are ignored
// - reset acts only while clock high
module quint_transparent_latch
   import quint_latch_pkg::*;
#(
   parameter int WIDTH = `LATCH_COUNT
) (
   input  wire logic             clk_i,
   input  wire logic             rst_i,
   input  wire logic             clock_in_a_i,
   input  wire logic             clock_in_b_i,
   input  wire logic             latch_reset_i,
   input  wire logic [WIDTH-1:0] latch_data_in_i,
   output logic      [WIDTH-1:0] latch_out_o,
   output logic                  latch_holding_o
);
   latch_ctrl_type   ctrl_sync;
   logic [WIDTH-1:0] data_sync;
   logic [WIDTH-1:0] next_out;
   latch_state_type  state;
   latch_state_type  next_state;

   pin_sync #(.WIDTH(WIDTH + 3)) u_sync (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .async_i ({clock_in_a_i, clock_in_b_i, latch_reset_i, latch_data_in_i}),
      .sync_o  ({ctrl_sync, data_sync})
   );

   wire comb_clock = ctrl_sync.clock_in_a | ctrl_sync.clock_in_b;
   wire reset_ok   = comb_clock & ctrl_sync.reset;

   // one clock function for all bits; state mirrors the combined clock
   always_comb begin
      next_state = state;
      next_out   = latch_out_o;
      case (state)
         st_pass: begin
            next_out = data_sync;
            if (comb_clock) begin
               next_state = st_hold;
               // data present at the rise is captured
               next_out   = reset_ok ? `LATCH_RESET_VAL : data_sync;
            end
         end
         st_hold: begin
            if (reset_ok) begin
               next_out = `LATCH_RESET_VAL;
            end
            if (!comb_clock) begin
               next_state = st_pass;
               next_out   = data_sync;
            end
         end
         default: begin
            next_state = st_pass;
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state           <= st_pass;
         latch_out_o     <= `LATCH_RESET_VAL;
         latch_holding_o <= 1'b0;
      end else begin
         state           <= next_state;
         latch_out_o     <= next_out;
         latch_holding_o <= (next_state == st_hold);
      end
   end

   a_pass_follows: assert property (@(posedge clk_i) disable iff (rst_i)
      !comb_clock |=> latch_out_o == $past(data_sync))
      else $error("output not following data while open");

   sequence s_rise;
      !comb_clock ##1 comb_clock;
   endsequence
   a_rise_capture: assert property (@(posedge clk_i) disable iff (rst_i)
      s_rise ##0 !ctrl_sync.reset |=> latch_out_o == $past(data_sync))
      else $error("rising clock did not capture data");

   a_hold_stable: assert property (@(posedge clk_i) disable iff (rst_i)
      comb_clock ##1 (comb_clock && !ctrl_sync.reset) |=> $stable(latch_out_o))
      else $error("held output changed while clock high");

   a_reset_gated: assert property (@(posedge clk_i) disable iff (rst_i)
      (!comb_clock && ctrl_sync.reset) |=> latch_out_o == $past(data_sync))
      else $error("reset acted while clock low");

   a_reset_clears: assert property (@(posedge clk_i) disable iff (rst_i)
      (comb_clock && ctrl_sync.reset) |=> latch_out_o == `LATCH_RESET_VAL)
      else $error("reset with clock high did not clear");

   a_or_clock: assert property (@(posedge clk_i) disable iff (rst_i)
      (ctrl_sync.clock_in_a ^ ctrl_sync.clock_in_b) |=> latch_holding_o)
      else $error("single clock input did not close latch");

   // the flag must track the combined clock one edge late, for all bits at once
   a_shared_ctrl: assert property (@(posedge clk_i) disable iff (rst_i)
      latch_holding_o == $past(comb_clock))
      else $error("holding flag disagrees with combined clock");

   a_hold_two: assert property (@(posedge clk_i) disable iff (rst_i)
      (comb_clock && !ctrl_sync.reset) [*2] |=> latch_out_o == $past(latch_out_o, 1))
      else $error("output moved during long hold");

   // closed for two edges in a row, the latch reset low on the second
   sequence s_closed;
      comb_clock ##1 (comb_clock && !ctrl_sync.reset);
   endsequence

   // reset seen while the latch is closed
   sequence s_clear;
      comb_clock && ctrl_sync.reset;
   endsequence

   // both clock inputs low must open the latch on the next edge
   a_open_flag: assert property (@(posedge clk_i) disable iff (rst_i)
      (!ctrl_sync.clock_in_a && !ctrl_sync.clock_in_b) |=> !latch_holding_o)
      else $error("latch stayed closed with both clocks low");

   // both clock inputs high close the latch just as one alone does
   a_both_close: assert property (@(posedge clk_i) disable iff (rst_i)
      (ctrl_sync.clock_in_a && ctrl_sync.clock_in_b) |=> latch_holding_o)
      else $error("latch open with both clocks high");

   // a cleared bank stays cleared once reset drops, until the clock falls
   a_clear_stays: assert property (@(posedge clk_i) disable iff (rst_i)
      s_clear ##1 (comb_clock && !ctrl_sync.reset) |=> latch_out_o == `LATCH_RESET_VAL)
      else $error("cleared output lost while clock high");

   // per-bit view: a wrong pairing of data bit to output bit shows up here,
   // where the whole-word checks above could hide a swap of two equal bits
   genvar b;
   generate
      for (b = 0; b < WIDTH; b++) begin : g_bit_chk
         a_bit_follows: assert property (@(posedge clk_i) disable iff (rst_i)
            !comb_clock |=> latch_out_o[b] == $past(data_sync[b]))
            else $error("output bit not following its data bit");

         a_bit_holds: assert property (@(posedge clk_i) disable iff (rst_i)
            s_closed |=> latch_out_o[b] == $past(latch_out_o[b]))
            else $error("output bit moved while latch closed");

         a_bit_clears: assert property (@(posedge clk_i) disable iff (rst_i)
            s_clear |=> latch_out_o[b] == 1'b0)
            else $error("output bit not cleared by reset");
      end
   endgenerate

   // helper count of closed edges with reset low; it saturates rather than
   // wrapping, so a very long hold never looks like a fresh capture
   logic [3:0] closed_run;

   always_ff @(posedge clk_i) begin
      if (rst_i || !comb_clock || ctrl_sync.reset) begin
         closed_run <= 4'h0;
      end else if (closed_run != 4'hf) begin
         closed_run <= closed_run + 4'h1;
      end
   end

   // the second and each further quiet closed edge in a row must itself leave outputs alone
   a_long_hold: assert property (@(posedge clk_i) disable iff (rst_i)
      (closed_run >= 4'h2) |-> $stable(latch_out_o))
      else $error("output drifted during a long hold");

   // limitation: pulses on any pin shorter than one clk_i period may be
   // missed by the synchroniser; the far side must hold levels that long
endmodule // quint_transparent_latch

// File: tb_quint_transparent_latch.sv
// self-checking bench for the five-bit latch bank
// assumes outputs settle within three clk_i edges of a pin change
`timescale 1ns/100ps
module tb_quint_transparent_latch
   import quint_latch_pkg::*;
;
   logic           clk_i = 1'b0;
   logic           rst_i = 1'b1;
   logic [7:0]     req = 8'h00;
   latch_ctrl_type ctrl;
   latch_word_type data, latch_out_o;
   logic           latch_holding_o;
   int             mismatches = 0;
   int             total_checks = 0;
   // {a, b, reset, data, expected out, expected holding}, run in order
   logic [13:0]    rows [9] = '{{3'h0,5'h15,5'h15,1'h1 ^ 1'h1}, {3'h4,5'h15,5'h15,1'h1},
      {3'h4,5'h0a,5'h15,1'h1}, {3'h6,5'h0a,5'h15,1'h1}, {3'h1,5'h0a,5'h0a,1'h0},
      {3'h3,5'h0a,5'h00,1'h1}, {3'h2,5'h1f,5'h00,1'h1}, {3'h0,5'h1f,5'h1f,1'h0},
      {3'h0,5'h11,5'h11,1'h0}};
   always #5 clk_i = ~clk_i;
   quint_latch_far_side far (.clk_i(clk_i), .req_i(req), .ctrl_o(ctrl), .data_o(data));
   quint_transparent_latch DUT (.clk_i(clk_i), .rst_i(rst_i),
      .clock_in_a_i(ctrl.clock_in_a), .clock_in_b_i(ctrl.clock_in_b),
      .latch_reset_i(ctrl.reset), .latch_data_in_i(data),
      .latch_out_o(latch_out_o), .latch_holding_o(latch_holding_o));
   task automatic chk(input logic [5:0] exp);
      total_checks++;
      if ({latch_out_o, latch_holding_o} !== exp) begin
         mismatches++;
         $display("BAD t=%0t got %h exp %h", $time, {latch_out_o, latch_holding_o}, exp);
      end
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      repeat (6) @(negedge clk_i);
      rst_i = 1'b0;
      foreach (rows[i]) begin
         @(posedge clk_i);
         req = rows[i][13:6];
         repeat (5) @(negedge clk_i);
         chk(rows[i][5:0]);
      end
      // reset in mid-run while transparent: cleared, then follows data again
      rst_i = 1'b1;
      repeat (2) @(negedge clk_i);
      chk(6'h00);
      rst_i = 1'b0;
      repeat (5) @(negedge clk_i);
      chk({5'h11, 1'h0});
      close_out();
   end
   initial begin
      #20000;
      mismatches++;
      close_out();
   end
endmodule // tb_quint_transparent_latch
